// ---- hdl/irq_prio_pkg.sv ----
// Package with register offsets, field layouts, reset values and types of the interrupt priority block.
package irq_prio_pkg;

  localparam int          NUM_SOURCES     = 7;
  localparam int          NUM_LEVELS      = 4;
  localparam int          LEVEL_W         = 2;

  // Register offsets and APB byte addresses of the registers.
  localparam logic [7:0]  PRIORITY_HIGH_OFFSET = 8'hB7;
  localparam logic [7:0]  PRIORITY_LOW_OFFSET  = 8'hB8;
  localparam logic [9:0]  PRIORITY_HIGH_BADDR  = {PRIORITY_HIGH_OFFSET, 2'b00};
  localparam logic [9:0]  PRIORITY_LOW_BADDR   = {PRIORITY_LOW_OFFSET, 2'b00};
  localparam logic [9:0]  EXT_CTRL_BADDR       = 10'h300;
  localparam logic [9:0]  IN_SERVICE_BADDR     = 10'h304;
  localparam logic [9:0]  IRQ_STATUS_BADDR     = 10'h308;
  localparam logic [9:0]  IRQ_CLEAR_BADDR      = 10'h30C;
  localparam logic [9:0]  IRQ_ENABLE_BADDR     = 10'h310;
  localparam logic [9:0]  VECTOR_BADDR         = 10'h314;

  // Values after reset.
  localparam logic [6:0]  PRIORITY_RESET  = 7'h00;
  localparam logic [1:0]  EXT_CTRL_RESET  = 2'h0;
  localparam logic [2:0]  IRQ_EN_RESET    = 3'h0;

  // Source positions in the priority registers and the request vector.
  localparam int          SRC_EXT0        = 0;
  localparam int          SRC_TIMER0      = 1;
  localparam int          SRC_EXT1        = 2;
  localparam int          SRC_TIMER1      = 3;
  localparam int          SRC_SERIAL      = 4;
  localparam int          SRC_TIMER2      = 5;
  localparam int          SRC_COUNTER_ARRAY = 6;

  // Vector of source 0 and the spacing between vectors.
  localparam logic [7:0]  VECTOR_BASE     = 8'h03;
  localparam logic [7:0]  VECTOR_STEP     = 8'h08;

  // Status bit positions of the block's own events.
  localparam int          EV_VECTORED     = 0;
  localparam int          EV_PREEMPTED    = 1;
  localparam int          EV_RETURNED     = 2;

  typedef logic [LEVEL_W-1:0] level_t;

  // Outcome of arbitration travelling from the arbiter to the controller.
  typedef struct packed {
    logic       valid;
    logic [2:0] source;
    level_t     level;
  } winner_t;

  // Request presented to the CPU core.
  typedef struct packed {
    logic       valid;
    logic [2:0] source;
    logic [7:0] vector;
  } vector_req_t;

endpackage

// ---- hdl/irq_priority_ctrl.sv ----
// Four-level interrupt priority and nesting controller with an APB register slave.
`timescale 1ns/1ps

// Summary of operation
// [R1] Arbitrate seven sources over four levels.
// [R2] Level bits 00 to 11 give levels 0 to 3.
// [R3] Serve request unless equal or higher in service.
// [R4] Hold request while equal or higher level runs.
// [R5] Higher level preempts lower handler immediately.
// [R6] Resume interrupted handler after preempting one returns.
// [R7] High register bits map sources; bit 7 unused.
// [R8] Pair high and low bits per source.
// [R9] High priority register sits at B7H.
// [R10] Edge-mode external flags cleared on service only.
// [R11] Fixed poll order, vectors 03H to 33H.
// [R12] Software clears serial, timer 2, counter-array flags.
module irq_priority_ctrl
  import irq_prio_pkg::*;
#(
  parameter int N = NUM_SOURCES
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  // APB slave.
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic              pready,
  output logic [31:0]       prdata,
  output logic              pslverr,
  // Request lines from the peripherals, already in this clock domain.
  input  wire logic [N-1:0] source_request,
  // Handshake with the CPU core.
  output vector_req_t       vector_request,
  input  wire logic         vector_ack,
  input  wire logic         handler_return,
  // Automatic clear of the two external request flags.
  output logic              ext0_request_clear,
  output logic              ext1_request_clear,
  output logic              irq
);

  // The register layout has one bit per source, so the count is fixed.
  if (N != NUM_SOURCES) begin : gen_bad_count
    $error("irq_priority_ctrl is laid out for exactly seven sources");
  end

  logic [N-1:0] priority_high_reg;
  logic [N-1:0] priority_low_reg;
  logic [1:0]   ext_edge_mode;
  logic [2:0]   irq_status;
  logic [2:0]   irq_enable;
  logic [7:0]   last_vector;
  winner_t      winner;
  logic [3:0]   in_service;
  level_t       top_level;
  logic         active;
  logic         take;
  logic         wr_en;
  logic         rd_en;
  logic         addr_hit;
  logic [9:0]   byte_addr;
  logic [2:0]   events;

  // Vector address of a source index.
  function automatic logic [7:0] vector_of(input logic [2:0] src);
    vector_of = VECTOR_BASE + 8'(src) * VECTOR_STEP; // [R11]
  endfunction

  // Every transfer completes in its access cycle, so pready can be a constant level.
  assign pready    = 1'b1;
  assign byte_addr = paddr[9:0];
  assign wr_en     = psel && penable && pwrite;
  assign rd_en     = psel && penable && !pwrite;
  assign addr_hit  = (paddr[11:10] == 2'b00) &&
                     (byte_addr == PRIORITY_HIGH_BADDR || byte_addr == PRIORITY_LOW_BADDR ||
                      byte_addr == EXT_CTRL_BADDR || byte_addr == IN_SERVICE_BADDR ||
                      byte_addr == IRQ_STATUS_BADDR || byte_addr == IRQ_CLEAR_BADDR ||
                      byte_addr == IRQ_ENABLE_BADDR || byte_addr == VECTOR_BADDR);
  assign pslverr   = psel && penable && !addr_hit;

  // Priority registers; bit 7 of each is not implemented and reads zero.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      priority_high_reg <= PRIORITY_RESET;
      priority_low_reg  <= PRIORITY_RESET;
    end else if (wr_en && byte_addr == PRIORITY_HIGH_BADDR) begin
      priority_high_reg <= pwdata[N-1:0]; // [R7] [R9]
    end else if (wr_en && byte_addr == PRIORITY_LOW_BADDR) begin
      priority_low_reg  <= pwdata[N-1:0];
    end
  end

  // Trigger mode of the two external inputs: 1 means transition, 0 means level.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ext_edge_mode <= EXT_CTRL_RESET;
    end else if (wr_en && byte_addr == EXT_CTRL_BADDR) begin
      ext_edge_mode <= pwdata[1:0];
    end
  end

  // Arbiter picks one winner among all seven request lines.
  prio_arbiter #(
    .N          (N)
  ) u_arbiter (
    .pending    (source_request), // [R1]
    .level_msb  (priority_high_reg),
    .level_lsb  (priority_low_reg),
    .in_service (in_service),
    .winner     (winner)
  );

  // A vector is taken when the core acknowledges an offered request.
  assign take = vector_ack && vector_request.valid;

  // Levels in service, so a preempted handler resumes when the newer one returns.
  nest_stack u_nest (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .push       (take), // [R5]
    .push_level (winner.level),
    .pop        (handler_return && active), // [R6]
    .in_service (in_service),
    .top_level  (top_level),
    .active     (active)
  );

  // The offer follows the arbiter directly so that a preemption reaches the core at once.
  always_comb begin
    vector_request.valid  = winner.valid; // [R3] [R5]
    vector_request.source = winner.source;
    vector_request.vector = vector_of(winner.source); // [R11]
  end

  // External flags are cleared only for transition-triggered inputs; level inputs and the
  // serial, timer 2 and counter-array flags are left to software.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ext0_request_clear <= 1'b0;
      ext1_request_clear <= 1'b0;
    end else begin
      ext0_request_clear <= take && winner.source == 3'(SRC_EXT0) && ext_edge_mode[0]; // [R10]
      ext1_request_clear <= take && winner.source == 3'(SRC_EXT1) && ext_edge_mode[1]; // [R10]
    end
  end

  // Last vector handed to the core, for software inspection.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      last_vector <= 8'h00;
    end else if (take) begin
      last_vector <= vector_request.vector;
    end
  end

  // Block events: a vector taken, a handler preempted, a handler returned.
  assign events = {handler_return && active, take && active, take};

  // Sticky status; a new event in the clearing cycle wins over the clear.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_status <= 3'h0;
    end else begin
      irq_status <= (irq_status & ~((wr_en && byte_addr == IRQ_CLEAR_BADDR) ? pwdata[2:0] : 3'h0))
                    | events;
    end
  end

  // Interrupt enable register.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq_enable <= IRQ_EN_RESET;
    end else if (wr_en && byte_addr == IRQ_ENABLE_BADDR) begin
      irq_enable <= pwdata[2:0];
    end
  end

  assign irq = |(irq_status & irq_enable);

  // Read data is registered; it appears in the access cycle from the setup-cycle address.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (byte_addr)
        PRIORITY_HIGH_BADDR: prdata <= {25'h0, priority_high_reg};
        PRIORITY_LOW_BADDR:  prdata <= {25'h0, priority_low_reg};
        EXT_CTRL_BADDR:      prdata <= {30'h0, ext_edge_mode};
        IN_SERVICE_BADDR:    prdata <= {28'h0, in_service};
        IRQ_STATUS_BADDR:    prdata <= {29'h0, irq_status};
        IRQ_ENABLE_BADDR:    prdata <= {29'h0, irq_enable};
        VECTOR_BADDR:        prdata <= {24'h0, last_vector};
        default:             prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// ---- hdl/nest_stack.sv ----
// Record of the levels currently in service, one bit per level.
`timescale 1ns/1ps
module nest_stack
  import irq_prio_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic push,
  input  level_t    push_level,
  input  wire logic pop,
  output logic [3:0] in_service,
  output level_t    top_level,
  output logic      active
);

  // Only higher levels nest, so the highest set bit is always the running handler.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      in_service <= 4'h0;
    end else begin
      in_service <= (pop ? (in_service & ~(4'h1 << top_level)) : in_service)
                    | (push ? (4'h1 << push_level) : 4'h0); // [R6]
    end
  end

  // The running handler is the highest bit set.
  always_comb begin
    top_level = '0;
    for (int i = 0; i < NUM_LEVELS; i++) begin
      if (in_service[i]) top_level = 2'(i);
    end
  end

  assign active = in_service != 4'h0;

endmodule

// ---- hdl/prio_arbiter.sv ----
// Level decode and fixed polling-order arbitration among the pending requests.
`timescale 1ns/1ps
module prio_arbiter
  import irq_prio_pkg::*;
#(
  parameter int N = NUM_SOURCES
) (
  input  wire logic [N-1:0] pending,
  input  wire logic [N-1:0] level_msb,
  input  wire logic [N-1:0] level_lsb,
  input  wire logic [3:0]   in_service,
  output winner_t           winner
);

  // A three-bit source index cannot name more than eight sources.
  if (N < 1 || N > 8) begin : gen_bad_count
    $error("prio_arbiter supports 1 to 8 sources");
  end

  // The highest level present wins; within a level the lowest index polls first.
  always_comb begin
    level_t best_level;
    logic   found;
    best_level = '0;
    found      = 1'b0;
    winner     = '0;
    for (int i = 0; i < N; i++) begin
      if (pending[i]) begin
        if (!found || level_t'({level_msb[i], level_lsb[i]}) > best_level) begin // [R2] [R8] [R11]
          best_level    = {level_msb[i], level_lsb[i]};
          found         = 1'b1;
          winner.source = 3'(i);
        end
      end
    end
    winner.level = best_level;
    // A request is offered only when nothing at its level or above is in service.
    winner.valid = found && ((in_service >> best_level) == 4'h0); // [R3] [R4] [R5]
  end

endmodule

// ---- sim/core_model.sv ----
// Behavioural CPU core that accepts offered vectors and ends handlers on command.
`timescale 1ns/1ps
module core_model
  import irq_prio_pkg::*;
(
  input  wire logic  ref_clk,
  input  wire logic  rst_n,
  input  vector_req_t vector_request,
  input  wire logic  ack_slow,
  input  wire logic  ret_cmd,
  output logic       vector_ack,
  output logic       handler_return
);
  logic [1:0] wait_cnt;

  // Accept an offer after one or three cycles; the ack drops at once so it stays a pulse.
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !vector_request.valid || vector_ack) begin
      wait_cnt   <= 2'h0;
      vector_ack <= 1'b0;
    end else begin
      wait_cnt   <= wait_cnt + 2'h1;
      vector_ack <= (wait_cnt >= (ack_slow ? 2'h2 : 2'h0));
    end
  end

  // A handler ends only when the bench says so, as software running it would.
  always_ff @(posedge ref_clk) begin
    handler_return <= rst_n & ret_cmd;
  end
endmodule

// ---- sim/irq_prio_checker_assertions.sv ----
// Assertions on the priority controller's ports.
`timescale 1ns/1ps
module irq_prio_checker
  import irq_prio_pkg::*;
#(
  parameter int N = NUM_SOURCES
) (
  input wire logic         ref_clk,
  input wire logic         rst_n,
  input wire logic         psel,
  input wire logic         penable,
  input wire logic         pready,
  input wire logic         pslverr,
  input wire logic [N-1:0] source_request,
  input vector_req_t       vector_request,
  input wire logic         vector_ack,
  input wire logic         ext0_request_clear,
  input wire logic         ext1_request_clear
);
  logic [3:0] took;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Remember which source the core accepted, so a clear pulse can be traced to it.
  always_ff @(posedge ref_clk) begin
    took <= {vector_ack & vector_request.valid, vector_request.source};
  end

  // An offer names a live source and carries its fixed vector.
  AST_VEC: assert property (vector_request.valid |-> vector_request.vector ==
    VECTOR_BASE + VECTOR_STEP * vector_request.source) else $error("bad vector");
  AST_LIVE: assert property (vector_request.valid |-> source_request[vector_request.source])
    else $error("offer without its request");
  AST_IDLE: assert property (source_request == '0 |-> !vector_request.valid)
    else $error("offer with nothing pending");
  // The taken level is in service one cycle later, so the same source must not be offered again.
  AST_HOLD: assert property (vector_ack && vector_request.valid |=>
    !(vector_request.valid && vector_request.source == $past(vector_request.source))) else $error("offer repeated");
  // Hardware clears an external flag only right after that source was accepted.
  AST_CLR0: assert property (ext0_request_clear |-> took == 4'h8) else $error("stray clear 0");
  AST_CLR1: assert property (ext1_request_clear |-> took == 4'hA) else $error("stray clear 1");
  AST_PULSE: assert property (ext0_request_clear |=> !ext0_request_clear) else $error("long clear");
  AST_RDY: assert property (pready) else $error("wait state seen");
  AST_ERR: assert property (pslverr |-> psel && penable) else $error("error outside access");

  // Main scenarios reached.
  cover property (vector_ack && vector_request.valid);
  cover property (ext0_request_clear);
  cover property (pslverr);
endmodule

bind irq_priority_ctrl irq_prio_checker #(.N(N)) irq_prio_checker_i (.ref_clk, .rst_n, .psel, .penable, .pready,
  .pslverr, .source_request, .vector_request, .vector_ack, .ext0_request_clear, .ext1_request_clear);

// ---- sim/tb_top.sv ----
// Self-checking bench for the interrupt priority controller.
`timescale 1ns/1ps
module tb_top
  import irq_prio_pkg::*;
;
  logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, rd_err, irq, ack_slow, ret_cmd;
  logic        vector_ack, handler_return, ext0_request_clear, ext1_request_clear;
  logic [1:0]  clr;
  logic [6:0]  source_request;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  vector_req_t vector_request;
  int          errors, tests_run;

  // Block under test and the core that serves its offers.
  irq_priority_ctrl irq_priority_ctrl_i (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .source_request, .vector_request, .vector_ack, .handler_return, .ext0_request_clear,
    .ext1_request_clear, .irq);
  core_model core_model_i (.ref_clk, .rst_n, .vector_request, .ack_slow, .ret_cmd, .vector_ack, .handler_return);

  // Free-running core clock.
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic complete_run();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // A wait that never ends is a failure, not a hang.
  task automatic stall();
    errors++;
    complete_run();
  endtask

  // One APB transfer; read data and error are taken at the completing edge, then one idle cycle.
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    int k;
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, 2'h0, a, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) stall();
    {rd, rd_err} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
    @(posedge ref_clk);
  endtask

  // Wait for the core's ack, check the offered vector, and note the clear pulses after it.
  task automatic serve(input logic [7:0] v);
    int k;
    k = 0;
    #1;
    while (vector_ack !== 1'b1 && k < 40) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    if (vector_ack !== 1'b1) stall();
    check({24'h0, vector_request.vector}, {24'h0, v});
    @(posedge ref_clk);
    @(negedge ref_clk);
    clr = {ext1_request_clear, ext0_request_clear};
    @(posedge ref_clk);
  endtask

  task automatic finish_handler();
    ret_cmd <= 1'b1;
    @(posedge ref_clk);
    ret_cmd <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask

  // Bit 7 of the high register is unused, and an unmapped address is refused.
  task automatic t_regs();
    apb(1'b1, PRIORITY_HIGH_BADDR, 32'hFF);
    apb(1'b0, PRIORITY_HIGH_BADDR, 32'h0);
    check(rd, 32'h7F);
    apb(1'b1, PRIORITY_HIGH_BADDR, 32'h0);
    apb(1'b0, 10'h3FC, 32'h0);
    check({31'h0, rd_err}, 32'h1);
    $display("test regs done");
  endtask

  // All seven sources at level 0 pending at once are served in polling order.
  task automatic t_order();
    source_request <= 7'h7F;
    for (int i = 0; i < 7; i++) begin
      serve(VECTOR_BASE + VECTOR_STEP * 8'(i));
      source_request[i] <= 1'b0;
      finish_handler();
    end
    $display("test order done");
  endtask

  // Sticky events, masking, and write-one clearing.
  task automatic t_irq();
    apb(1'b0, IRQ_STATUS_BADDR, 32'h0);
    check(rd, 32'h5);
    apb(1'b1, IRQ_ENABLE_BADDR, 32'h1);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, IRQ_ENABLE_BADDR, 32'h2);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, IRQ_CLEAR_BADDR, 32'h7);
    apb(1'b0, IRQ_STATUS_BADDR, 32'h0);
    check(rd, 32'h0);
    $display("test irq done");
  endtask

  // Level 3 preempts level 0 while a level 0 request waits, then nesting unwinds.
  task automatic t_nest();
    apb(1'b1, EXT_CTRL_BADDR, 32'h1);
    apb(1'b1, PRIORITY_HIGH_BADDR, 32'h8);
    apb(1'b1, PRIORITY_LOW_BADDR, 32'h8);
    ack_slow <= 1'b1;
    source_request <= 7'h01;
    serve(8'h03);
    check({30'h0, clr}, 32'h1);
    source_request <= 7'h0C;
    serve(8'h1B);
    check({31'h0, irq}, 32'h1);
    source_request <= 7'h04;
    apb(1'b0, IN_SERVICE_BADDR, 32'h0);
    check(rd, 32'h9);
    check({31'h0, vector_request.valid}, 32'h0);
    finish_handler();
    check({31'h0, vector_request.valid}, 32'h0);
    finish_handler();
    serve(8'h13);
    check({30'h0, clr}, 32'h0);
    source_request <= 7'h00;
    finish_handler();
    apb(1'b0, IRQ_STATUS_BADDR, 32'h0);
    check(rd, 32'h7);
    $display("test nest done");
  endtask

  // Levels 1 and 2 against each other and level 0, with the second external input edge-triggered.
  task automatic t_levels();
    apb(1'b1, EXT_CTRL_BADDR, 32'h2);
    apb(1'b1, PRIORITY_HIGH_BADDR, 32'h4);
    apb(1'b1, PRIORITY_LOW_BADDR, 32'h2);
    source_request <= 7'h16;
    serve(8'h13);
    check({30'h0, clr}, 32'h2);
    source_request <= 7'h12;
    @(posedge ref_clk);
    check({31'h0, vector_request.valid}, 32'h0);
    finish_handler();
    serve(8'h0B);
    source_request <= 7'h10;
    finish_handler();
    serve(8'h23);
    source_request <= 7'h00;
    finish_handler();
    apb(1'b0, VECTOR_BADDR, 32'h0);
    check(rd, 32'h23);
    $display("test levels done");
  endtask

  // Reset, then each scenario in turn.
  initial begin
    {errors, tests_run} = 64'h0;
    {rst_n, psel, penable, pwrite, ack_slow, ret_cmd, paddr, pwdata, source_request} = '0;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_regs();
    t_order();
    t_irq();
    t_nest();
    t_levels();
    complete_run();
  end
endmodule
